// ===== standby_power_defines.vh
// command codes, status/error bit positions and timer constants
// for the standby and buffer-write command handler
`ifndef STANDBY_POWER_DEFINES_VH
`define STANDBY_POWER_DEFINES_VH

// command codes
`define CMD_STANDBY        8'hE2
`define CMD_STANDBY_ALT    8'h96
`define CMD_STANDBY_IMM    8'hE0
`define CMD_STANDBY_IMM_A  8'h94
`define CMD_WRITE_BUF      8'hE8

// status bit positions
`define ST_BSY  7
`define ST_RDY  6
`define ST_DF   5
`define ST_DSC  4
`define ST_DRQ  3
`define ST_ERR  0
// error bit positions
`define ER_ABT  2

// timeout byte decode bounds
`define TO_DISABLE   8'h00
`define TO_SEC_MAX   8'hF0
`define TO_HALF_MAX  8'hFB
`define TO_21MIN     8'hFC
`define TO_8HOUR     8'hFD
`define TO_ABORT     8'hFE
`define TO_21M15S    8'hFF

// timer units in seconds
`define TO_STEP_SEC   5
`define TO_HALF_SEC   1800
`define TO_21MIN_SEC  1260
`define TO_8HOUR_SEC  28800
`define TO_21M15_SEC  1275

// clock rate and seconds prescaler
`define CLK_HZ        50000000
`define SEC_CYCLES    (`CLK_HZ / 1)

// cycles the speed flag is ignored after a spin-up request
`define SYNC_SETTLE   2'd3

// sector buffer: 256 words of 16 bits = 512 bytes
`define BUF_WORDS     256
`define BUF_AW        8

`endif

// ===== standby_power_command_handler.v
// standby, standby-immediate and write-buffer command handler
// assumes command strobe/data strobes come from same-clock host logic;
// spindle speed flag comes from outside and is synchronised here
`include "standby_power_defines.vh"
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - standby commands enter standby, load timeout
// - spin down spindle only if spinning
// - accept commands, hold media ones until spun
// - timer counts only while drive idle
// - EPC enabled selects deepest standby condition
// - decode timeout zero, seconds, half-hour steps
// - special timeout values, 254 aborts
// - timer expiry enters standby automatically
// - host access reloads full timer interval
// - immediate standby command enters standby
// - immediate standby keeps stored timeout
// - write buffer takes 256 sixteen-bit words
// - buffer read returns same written sector
module standby_power_command_handler #(
  parameter SEC_CYCLES = `SEC_CYCLES
) (
  // clock, reset, enable
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  // command port
  input  wire        cmd_valid_i,
  input  wire [7:0]  cmd_code_i,
  input  wire [7:0]  sector_count_i,
  input  wire        media_cmd_i,
  input  wire        host_access_i,
  // data port
  input  wire        data_wr_i,
  input  wire [15:0] data_wr_data_i,
  input  wire        data_rd_i,
  output reg  [15:0] data_rd_data_o,
  // drive condition
  input  wire        epc_enable_i,
  input  wire        spindle_at_speed_i,
  output reg         spindle_run_o,
  output reg         standby_o,
  output reg         standby_z_o,
  output reg         apd_enabled_o,
  // task-file status
  output reg  [7:0]  status_o,
  output reg  [7:0]  error_o,
  output reg         cmd_done_o
);

  // behaviour summary for the next reader
  //
  // power conditions
  //   idle: spindle commanded on, timer may count down
  //   standby: spindle commanded off, commands still taken
  //   deep standby: standby entered while epc feature is on
  //   spin-up: media command seen in standby, waiting for speed
  //
  // status codes driven on status_o
  //   50h: ready, seek complete, nothing pending
  //   51h: ready with error bit, abort code in error_o
  //   58h: ready, data request open for the buffer sector
  //   D0h: busy, media command held until spindle at speed
  //
  // command acceptance
  //   taken only in idle or standby; ignored silently during
  //   a buffer transfer or a spin-up, so the host must wait
  //   for cmd_done_o before issuing the next command
  //
  // standby timer
  //   seconds come from a free-running prescaler, so an
  //   interval may end up to one tick early; accepted to
  //   keep a single counter instead of one per load
  //   the count is held while not idle and reloaded on
  //   every host access, media command and spin-up exit
  //   a zero timeout clears the enable, so expiry never fires
  //   an abort code leaves the stored timeout untouched
  //
  // speed flag
  //   it crosses from the motor domain through two flops;
  //   right after a spin-up request the synchroniser may
  //   still hold samples taken before the motor dropped,
  //   so the flag is ignored for a few cycles first
  //   a motor that never reports speed keeps the block
  //   busy; there is no timeout on spin-up by design
  //
  // sector buffer
  //   one 512-byte sector held as 256 words in flops;
  //   the write pointer and the read pointer both rewind
  //   when a buffer write is taken, so a following read
  //   returns the words just written, word 0 first
  //   reads outside a buffer command return stale words
  //
  // clock enable
  //   low freezes every register including the buffer

  // drive states
  localparam [1:0] S_IDLE    = 2'd0;
  localparam [1:0] S_STANDBY = 2'd1;
  localparam [1:0] S_SPINUP  = 2'd2;
  localparam [1:0] S_WBUF    = 2'd3;

  reg [1:0]          state;
  reg [31:0]         timeout_sec;
  reg [31:0]         remain_sec;
  reg [31:0]         presc;
  reg                pend_media;
  reg [`BUF_AW-1:0]  wr_ptr;
  reg [`BUF_AW-1:0]  rd_ptr;
  reg [15:0]         buf_mem [0:`BUF_WORDS-1];
  reg                spd_meta;
  reg                spd_sync;
  reg [1:0]          settle;

  // timeout byte to seconds; zero result means disabled
  function [31:0] decode_to;
    input [7:0] v;
    begin
      if (v == `TO_DISABLE)
        decode_to = 32'h0;
      else if (v <= `TO_SEC_MAX)
        decode_to = {24'h0, v} * `TO_STEP_SEC;
      else if (v <= `TO_HALF_MAX)
        decode_to = ({24'h0, v} - 32'd240) * `TO_HALF_SEC;
      else if (v == `TO_21MIN)
        decode_to = `TO_21MIN_SEC;
      else if (v == `TO_8HOUR)
        decode_to = `TO_8HOUR_SEC;
      else
        decode_to = `TO_21M15_SEC;
    end
  endfunction

  wire is_stby  = (cmd_code_i == `CMD_STANDBY) || (cmd_code_i == `CMD_STANDBY_ALT);
  wire is_imm   = (cmd_code_i == `CMD_STANDBY_IMM) || (cmd_code_i == `CMD_STANDBY_IMM_A);
  wire is_wbuf  = (cmd_code_i == `CMD_WRITE_BUF);
  wire tick     = (presc == SEC_CYCLES - 1);
  wire accept   = cmd_valid_i && (state != S_WBUF) && (state != S_SPINUP);

  // spindle speed flag from the motor domain, two stages
  always @(posedge clk_i) begin
    if (reset_i) begin
      spd_meta <= 1'b0;
      spd_sync <= 1'b0;
    end else if (ce_i) begin
      spd_meta <= spindle_at_speed_i;
      spd_sync <= spd_meta;
    end
  end

  // free-running seconds prescaler
  always @(posedge clk_i) begin
    if (reset_i)
      presc <= 32'h0;
    else if (ce_i)
      presc <= tick ? 32'h0 : presc + 32'd1;
  end

  // sector buffer storage; pointers rewind at each buffer write command start
  always @(posedge clk_i) begin
    if (ce_i && state == S_WBUF && data_wr_i)
      buf_mem[wr_ptr] <= data_wr_data_i;
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      rd_ptr         <= {`BUF_AW{1'b0}};
      data_rd_data_o <= 16'h0000;
    end else if (ce_i) begin
      if (accept && is_wbuf)
        rd_ptr <= {`BUF_AW{1'b0}};
      else if (data_rd_i) begin
        data_rd_data_o <= buf_mem[rd_ptr];
        rd_ptr         <= rd_ptr + 1'b1;
      end
    end
  end

  // command sequencing, power condition and standby timer
  always @(posedge clk_i) begin
    if (reset_i) begin
      state         <= S_IDLE;
      timeout_sec   <= 32'h0;
      remain_sec    <= 32'h0;
      pend_media    <= 1'b0;
      settle        <= 2'd0;
      wr_ptr        <= {`BUF_AW{1'b0}};
      spindle_run_o <= 1'b1;
      standby_o     <= 1'b0;
      standby_z_o   <= 1'b0;
      apd_enabled_o <= 1'b0;
      status_o      <= 8'h50;
      error_o       <= 8'h00;
      cmd_done_o    <= 1'b0;
    end else if (ce_i) begin
      cmd_done_o <= 1'b0;
      case (state)
        S_IDLE, S_STANDBY: begin
          if (accept && (is_stby || is_imm)) begin
            error_o <= 8'h00;
            if (is_stby && sector_count_i == `TO_ABORT) begin
              // no power change on abort
              error_o  <= 8'h04;
              status_o <= 8'h51;
            end else begin
              if (is_stby) begin
                timeout_sec   <= decode_to(sector_count_i);
                apd_enabled_o <= (sector_count_i != `TO_DISABLE);
              end
              spindle_run_o <= 1'b0;
              standby_o     <= 1'b1;
              standby_z_o   <= epc_enable_i;
              state         <= S_STANDBY;
              status_o      <= 8'h50;
            end
            cmd_done_o <= 1'b1;
          end else if (accept && is_wbuf) begin
            wr_ptr   <= {`BUF_AW{1'b0}};
            error_o  <= 8'h00;
            status_o <= 8'h58; // request data
            state    <= S_WBUF;
          end else if (accept && media_cmd_i) begin
            error_o <= 8'h00;
            if (state == S_STANDBY) begin
              // hold completion until spindle back at speed
              spindle_run_o <= 1'b1;
              pend_media    <= 1'b1;
              settle        <= `SYNC_SETTLE;
              status_o      <= 8'hD0;
              state         <= S_SPINUP;
            end else begin
              status_o   <= 8'h50;
              cmd_done_o <= 1'b1;
              remain_sec <= timeout_sec;
            end
          end else if (state == S_IDLE) begin
            if (host_access_i || accept)
              remain_sec <= timeout_sec;
            else if (apd_enabled_o && tick) begin
              // counts only while idle
              if (remain_sec <= 32'd1) begin
                spindle_run_o <= 1'b0;
                standby_o     <= 1'b1;
                standby_z_o   <= epc_enable_i;
                state         <= S_STANDBY;
              end else
                remain_sec <= remain_sec - 32'd1;
            end
          end
        end
        S_SPINUP: begin
          // stale synchroniser samples must not end the wait early
          if (settle != 2'd0)
            settle <= settle - 2'd1;
          else if (spd_sync) begin
            standby_o   <= 1'b0;
            standby_z_o <= 1'b0;
            pend_media  <= 1'b0;
            status_o    <= 8'h50;
            cmd_done_o  <= pend_media;
            remain_sec  <= timeout_sec;
            state       <= S_IDLE;
          end
        end
        S_WBUF: begin
          if (data_wr_i) begin
            wr_ptr <= wr_ptr + 1'b1;
            if (wr_ptr == `BUF_WORDS - 1) begin
              status_o   <= 8'h50;
              cmd_done_o <= 1'b1;
              state      <= standby_o ? S_STANDBY : S_IDLE;
              remain_sec <= timeout_sec;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // standby_power_command_handler

`default_nettype wire

// ===== standby_power_props.sv
// checker: one-cycle answers and the three-cycle media hold of the standby and buffer command handler
// assumes binding to the handler top; ports watched by name only
`timescale 1ns/10ps
`default_nettype none
module standby_power_props (
  // clock and reset
  input wire       clk_i,
  input wire       reset_i,
  input wire       ce_i,
  // command and condition inputs
  input wire       cmd_valid_i,
  input wire [7:0] cmd_code_i,
  input wire [7:0] sector_count_i,
  input wire       epc_enable_i,
  input wire       spindle_at_speed_i,
  // answers
  input wire       spindle_run_o,
  input wire       standby_o,
  input wire       standby_z_o,
  input wire       apd_enabled_o,
  input wire [7:0] status_o,
  input wire [7:0] error_o,
  input wire       cmd_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // accepted only when neither busy nor moving buffer data
  wire acc = cmd_valid_i && ce_i && !status_o[7] && !status_o[3];
  wire sb  = acc && (cmd_code_i == 8'hE2 || cmd_code_i == 8'h96);
  wire si  = acc && (cmd_code_i == 8'hE0 || cmd_code_i == 8'h94);
  wire ab  = sb && sector_count_i == 8'hFE;
  stby_enter_a: assert property (sb && !ab && sector_count_i != 8'h00 |=>
    standby_o && !spindle_run_o && apd_enabled_o && cmd_done_o) else $error("standby entry");
  timer_off_a: assert property (sb && sector_count_i == 8'h00 |=> !apd_enabled_o)
    else $error("zero timeout");
  imm_enter_a: assert property (si |=> standby_o && !spindle_run_o && cmd_done_o)
    else $error("immediate standby");
  imm_keep_a: assert property (si |=> $stable(apd_enabled_o))
    else $error("immediate changed timer");
  abort_code_a: assert property (ab |=> error_o == 8'h04 && status_o == 8'h51
    && cmd_done_o && $stable(standby_o)) else $error("abort answer");
  deep_stby_a: assert property ((sb && !ab || si) && epc_enable_i |=> standby_z_o)
    else $error("deep standby");
  media_hold_a: assert property (status_o == 8'hD0 && !spindle_at_speed_i |-> ##3 !cmd_done_o)
    else $error("early media completion");
  buf_start_a: assert property (acc && cmd_code_i == 8'hE8 |=> status_o == 8'h58
    && !cmd_done_o) else $error("buffer start");
endmodule // standby_power_props
bind standby_power_command_handler standby_power_props u_standby_power_props (.clk_i, .reset_i,
  .ce_i, .cmd_valid_i, .cmd_code_i, .sector_count_i, .epc_enable_i, .spindle_at_speed_i,
  .spindle_run_o, .standby_o, .standby_z_o, .apd_enabled_o, .status_o, .error_o, .cmd_done_o);
`default_nettype wire

// ===== spindle_motor_model.sv
// spindle motor stand-in: reports speed some cycles after run request
// assumes the run request is a level on the handler clock
`timescale 1ns/10ps
`default_nettype none
module spindle_motor_model #(
  parameter SPIN = 20
) (
  input  wire clk_i,
  input  wire run_i,
  output reg  at_speed_o = 1'b0
);
  integer cnt = 0;
  // slow spin-up on purpose; stopping drops the flag at once
  always @(posedge clk_i) begin
    cnt <= run_i ? (cnt < SPIN ? cnt + 1 : cnt) : 0;
    at_speed_o <= run_i && cnt >= SPIN;
  end
endmodule // spindle_motor_model
`default_nettype wire

// ===== standby_power_command_handler_tb.sv
// testbench: command sequences with expected power, status and buffer data
// assumes the handler, the motor stand-in and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module standby_power_command_handler_tb;
  reg         clk_i, reset_i, cmd_valid_i, media_cmd_i, host_access_i;
  reg         data_wr_i, data_rd_i, epc_enable_i;
  reg  [7:0]  cmd_code_i, sector_count_i;
  reg  [15:0] data_wr_data_i;
  wire [15:0] data_rd_data_o;
  wire [7:0]  status_o, error_o;
  wire        fast, spindle_run_o, standby_o, standby_z_o, apd_enabled_o, cmd_done_o;
  integer     fails = 0, checks_done = 0, i;
  // power flags packed: standby, deep, spindle run, timer enabled
  wire [15:0] pw = {12'h000, standby_o, standby_z_o, spindle_run_o, apd_enabled_o};
  standby_power_command_handler #(.SEC_CYCLES(10)) u_standby_power_command_handler (
    .clk_i, .reset_i, .ce_i(1'b1), .cmd_valid_i, .cmd_code_i, .sector_count_i, .media_cmd_i,
    .host_access_i, .data_wr_i, .data_wr_data_i, .data_rd_i, .data_rd_data_o, .epc_enable_i,
    .spindle_at_speed_i(fast), .spindle_run_o, .standby_o, .standby_z_o, .apd_enabled_o,
    .status_o, .error_o, .cmd_done_o);
  spindle_motor_model u_spindle_motor_model (.clk_i, .run_i(spindle_run_o), .at_speed_o(fast));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task step;
    @(posedge clk_i);
    #1;
  endtask
  // bounded wait for completion, then one spare cycle before the next command
  task wait_done;
    integer n;
    n = 0;
    while (cmd_done_o !== 1'b1) begin
      if (n == 300) begin
        fails = fails + 1;
        complete_run;
      end
      n = n + 1;
      step;
    end
    step;
  endtask
  task cmd(input [7:0] c, input [7:0] s, input m);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    sector_count_i = s;
    media_cmd_i = m;
    step;
    cmd_valid_i = 1'b0;
    media_cmd_i = 1'b0;
    if (c != 8'hE8) wait_done;
  endtask
  // media command from standby spins the drive up again
  task wake;
    cmd(8'hC8, 8'h00, 1'b1);
  endtask
  initial begin
    {cmd_valid_i, media_cmd_i, host_access_i, data_wr_i, data_rd_i, epc_enable_i} = 6'h00;
    cmd_code_i = 8'h00;
    sector_count_i = 8'h00;
    data_wr_data_i = 16'h0000;
    reset_i = 1'b1;
    repeat (16) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk("status", 16'h0050, {8'h00, status_o});
    chk("power", 16'h0002, pw);
    cmd(8'h96, 8'h00, 1'b0); chk("power", 16'h0008, pw);
    wake; chk("power", 16'h0002, pw);
    cmd(8'hE2, 8'hFE, 1'b0); chk("error", 16'h0004, {8'h00, error_o});
    chk("status", 16'h0051, {8'h00, status_o});
    cmd(8'hE2, 8'h01, 1'b0); chk("power", 16'h0009, pw);
    cmd(8'hE0, 8'h00, 1'b0); chk("power", 16'h0009, pw);
    wake;
    epc_enable_i = 1'b1;
    cmd(8'h94, 8'h00, 1'b0); chk("power", 16'h000D, pw);
    epc_enable_i = 1'b0;
    $display("test commands done");
    // timer of 5 ticks of 10 cycles, reloaded part way by a host access
    wake;
    repeat (35) step;
    chk("power", 16'h0003, pw);
    host_access_i = 1'b1;
    step;
    host_access_i = 1'b0;
    repeat (35) step;
    chk("power", 16'h0003, pw);
    for (i = 0; i < 40 && standby_o !== 1'b1; i = i + 1) step;
    chk("power", 16'h0009, pw);
    $display("test timer done");
    cmd(8'hE8, 8'h00, 1'b0); chk("status", 16'h0058, {8'h00, status_o});
    for (i = 0; i < 256; i = i + 1) begin
      data_wr_i = 1'b1;
      data_wr_data_i = i[15:0] * 16'h0301 ^ 16'hA5C3;
      step;
    end
    data_wr_i = 1'b0;
    wait_done; chk("status", 16'h0050, {8'h00, status_o});
    for (i = 0; i < 256; i = i + 1) begin
      data_rd_i = 1'b1;
      step;
      data_rd_i = 1'b0;
      step;
      chk("buffer", i[15:0] * 16'h0301 ^ 16'hA5C3, data_rd_data_o);
    end
    $display("test buffer done");
    complete_run;
  end
endmodule // standby_power_command_handler_tb
`default_nettype wire
